/* File: scsi_dma_feature_control_tb.sv */
// Self-checking bench for the SCSI DMA feature control block
`timescale 1ns/1ps
module scsi_dma_feature_control_tb;
  // ==========================================================================
  // Signals
  logic        clk_i, rst_i, soft_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
  logic [5:0]  wb_adr_i, glitch_window_ns_o;
  logic [3:0]  wb_sel_i, max_sync_offset_o;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        dma_active_i, dma_read_i, dma_wide_i, target_mode_i, xfer_done_i;
  logic        atn_active_i, ctc_zero_i, phase_change_i, sync_data_in_i, sdi_interrupted_i;
  logic        last_odd_byte_i, first_word_i, fifo_byte_par_i, en, slow, rseen, rerr;
  logic [1:0]  bus_mode_field_i, upper_parity_lane_o, glitch_filter_select_o;
  logic [7:0]  event_count_i, fifo_byte_lo_i, fifo_byte_hi_i, rbyte, d, r;
  logic [4:0]  fifo_count_i;
  logic        dma_read_strobe_i, dma_write_strobe_i, dma_request_o, dma_acknowledge_o;
  logic [15:0] dma_data_o;
  logic        fast_timing_o, scsi_input_enable_o, negation_req_ack_o, negation_data_o;
  logic        queue_tag_message_enable_o, ten_byte_cdb_enable_o, back_to_back_o, rq_p, ak_p;
  int          bad_count, check_count, scnt, rqf, akf;
  int          gw[4] = '{12, 35, 25, 0};

  sdf_feature_ctrl dut_u (.clk_i, .rst_i, .soft_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .dma_active_i,
    .dma_read_i, .dma_wide_i, .bus_mode_field_i, .target_mode_i, .xfer_done_i,
    .atn_active_i, .ctc_zero_i, .phase_change_i, .sync_data_in_i, .sdi_interrupted_i,
    .event_count_i, .fifo_count_i, .last_odd_byte_i, .first_word_i, .fifo_byte_lo_i,
    .fifo_byte_hi_i, .fifo_byte_par_i, .dma_read_strobe_i, .dma_write_strobe_i,
    .dma_request_o, .dma_acknowledge_o, .dma_data_o, .upper_parity_lane_o, .fast_timing_o,
    .max_sync_offset_o, .glitch_filter_select_o, .glitch_window_ns_o, .scsi_input_enable_o,
    .negation_req_ack_o, .negation_data_o, .queue_tag_message_enable_o,
    .ten_byte_cdb_enable_o, .back_to_back_o);

  sdf_dma_host host_u (.clk_i(clk_i), .en_i(en), .dir_read_i(dma_read_i), .slow_i(slow),
    .dma_request_i(dma_request_o), .dma_read_strobe_o(dma_read_strobe_i),
    .dma_write_strobe_o(dma_write_strobe_i), .strobe_count_o(scnt));

  // ==========================================================================
  // Clock, watchdog and handshake edge counters
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    results();
  end

  always @(posedge clk_i)
  begin
    if (rq_p === 1'b1 && dma_request_o === 1'b0) rqf++;
    if (ak_p === 1'b1 && dma_acknowledge_o === 1'b0) akf++;
    rq_p = dma_request_o;
    ak_p = dma_acknowledge_o;
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] v);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, v};
    wb_sel_i <= 4'hF;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
    rbyte = wb_dat_o[7:0];
    rerr = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) bad_count++;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk({24'h000000, rbyte}, {24'h000000, e}, "register read");
  endtask

  // Watches the request for a fixed span; idle() drops activity so the next check starts idle
  task automatic req_seen();
    rseen = 1'b0;
    dma_active_i <= 1'b1;
    repeat (20)
    begin
      @(posedge clk_i);
      if (dma_request_o === 1'b1) rseen = 1'b1;
    end
  endtask

  task automatic idle();
    dma_active_i <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask

  task automatic strobes(input int n);
    int b;
    int k;
    b = scnt;
    k = 0;
    rqf = 0;
    akf = 0;
    dma_active_i <= 1'b1;
    en <= 1'b1;
    while (scnt < b + n && k < 400)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 400) bad_count++;
    en <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    {rst_i, soft_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, en, slow} = 7'h41;
    {wb_adr_i, wb_sel_i, wb_dat_i, bus_mode_field_i, event_count_i, fifo_count_i} = '0;
    {dma_active_i, dma_read_i, target_mode_i, xfer_done_i, atn_active_i} = '0;
    {ctc_zero_i, phase_change_i, sync_data_in_i, sdi_interrupted_i} = '0;
    {last_odd_byte_i, first_word_i} = '0;
    dma_wide_i = 1'b1;
    void'($urandom(32'hB66E));
    {fifo_byte_lo_i, fifo_byte_hi_i, fifo_byte_par_i} = 17'($urandom);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(32'(back_to_back_o), 32'h1, "back to back");
    chk(32'(max_sync_offset_o), 32'hF, "reset offset");
    rd_chk(6'h30, 8'h00);
    rd_chk(6'h34, 8'h10);
    wb(1'b0, 6'h08, 8'h00);
    chk(32'(rerr), 32'h1, "unmapped index");
    for (int k = 0; k < 4; k++)
    begin
      r = 8'($urandom);
      d = {1'b0, r[6:5], 2'(k), 1'b0, (k == 2) ? 2'b11 : 2'(k)};
      wb(1'b1, 6'h30, d);
      chk(32'(fast_timing_o), 32'(d[4] & d[3]), "fast timing");
      chk(32'(max_sync_offset_o), (d[1:0] == 2'b00) ? 32'hF : 32'h7, "offset");
      rd_chk(6'h30, d);
      chk({queue_tag_message_enable_o, ten_byte_cdb_enable_o}, d[6:5], "message options");
    end
    for (int g = 0; g < 4; g++)
    begin
      r = 8'($urandom);
      d = {2'(g), g[1], 1'b0, 2'(g), 1'b0, r[0]};
      wb(1'b1, 6'h34, d);
      chk(32'(glitch_window_ns_o), 32'(gw[g]), "glitch window");
      chk(32'(glitch_filter_select_o), 32'(g), "glitch select");
      chk(32'(scsi_input_enable_o), 32'(!d[5]), "input enable");
      chk({negation_req_ack_o, negation_data_o}, {d[3] | d[2], d[2]}, "negation");
      chk(32'(back_to_back_o), 32'h1, "back to back");
      rd_chk(6'h34, (d & 8'hE5) | 8'h10);
    end
    wb(1'b1, 6'h30, 8'h04);
    soft_rst_i <= 1'b1;
    @(posedge clk_i);
    soft_rst_i <= 1'b0;
    rd_chk(6'h30, 8'h00);
    slow <= 1'b1;
    strobes(4);
    chk(32'(rqf), 32'h4, "request falls");
    chk(32'(akf), 32'h4, "acknowledge falls");
    idle();
    wb(1'b1, 6'h30, 8'h03);
    fifo_count_i <= 5'h09;
    req_seen();
    chk(32'(rseen), 32'h0, "burst write seven free");
    fifo_count_i <= 5'h08;
    req_seen();
    chk(32'(rseen), 32'h1, "burst write eight free");
    slow <= 1'b0;
    strobes(4);
    chk(32'(akf), 32'h0, "held acknowledge");
    idle();
    {dma_read_i, bus_mode_field_i, fifo_count_i} <= {1'b1, 2'b11, 5'h10};
    strobes(3);
    chk(32'(akf), 32'h3, "read acknowledge in mode 11");
    idle();
    {bus_mode_field_i, fifo_count_i} <= {2'b00, 5'h07};
    req_seen();
    chk(32'(rseen), 32'h0, "burst read seven held");
    ctc_zero_i <= 1'b1;
    req_seen();
    chk(32'(rseen), 32'h1, "count reached zero");
    idle();
    {ctc_zero_i, target_mode_i, xfer_done_i} <= 3'b011;
    req_seen();
    chk(32'(rseen), 32'h1, "target completion");
    idle();
    {target_mode_i, xfer_done_i, sync_data_in_i, event_count_i, fifo_count_i} <=
      {2'b00, 1'b1, 8'h07, 5'h08};
    req_seen();
    chk(32'(rseen), 32'h0, "event count seven");
    event_count_i <= 8'h08;
    req_seen();
    chk(32'(rseen), 32'h1, "event count eight");
    idle();
    sync_data_in_i <= 1'b0;
    wb(1'b1, 6'h30, 8'h04);
    last_odd_byte_i <= 1'b1;
    req_seen();
    chk(32'(rseen), 32'h0, "last byte held back");
    idle();
    dma_wide_i <= 1'b0;
    req_seen();
    chk(32'(rseen), 32'h1, "narrow ignores last byte mode");
    idle();
    dma_wide_i <= 1'b1;
    bus_mode_field_i <= 2'b10;
    wb(1'b1, 6'h2C, 8'h20);
    req_seen();
    chk(32'(rseen), 32'h1, "byte order ignores last byte mode");
    idle();
    bus_mode_field_i <= 2'b00;
    wb(1'b1, 6'h2C, 8'h00);
    wb(1'b1, 6'h30, 8'h00);
    req_seen();
    chk(32'(rseen), 32'h1, "last byte requested");
    chk({upper_parity_lane_o[1], dma_data_o[15:8]}, 9'h1FF, "upper lanes");
    idle();
    last_odd_byte_i <= 1'b0;
    wb(1'b1, 6'h2C, 8'h80);
    rd_chk(6'h2C, 8'h80);
    r = 8'($urandom);
    wb(1'b1, 6'h3C, r);
    {sync_data_in_i, first_word_i} <= 2'b11;
    repeat (2) @(posedge clk_i);
    chk(32'(dma_data_o), {16'h0000, fifo_byte_lo_i, r}, "aligned first word");
    first_word_i <= 1'b0;
    {sync_data_in_i, sdi_interrupted_i} <= 2'b11;
    wb(1'b1, 6'h3C, 8'($urandom));
    rd_chk(6'h2C, 8'h00);
    rd_chk(6'h3C, 8'h00);
    results();
  end
endmodule // scsi_dma_feature_control_tb

/* File: sdf_dma_host.sv */
// Behavioural model of the external DMA controller that answers requests with strobes
`timescale 1ns/1ps
module sdf_dma_host
(
  input  wire logic clk_i,
  input  wire logic en_i,
  input  wire logic dir_read_i,
  input  wire logic slow_i,
  input  wire logic dma_request_i,
  output logic      dma_read_strobe_o,
  output logic      dma_write_strobe_o,
  output int        strobe_count_o
);
  // ==========================================================================
  // Strobe generator
  initial
  begin
    dma_read_strobe_o  = 1'b0;
    dma_write_strobe_o = 1'b0;
    strobe_count_o     = 0;
    forever
    begin
      @(posedge clk_i);
      // Never strobes unless the device asks first
      if (en_i && dma_request_i === 1'b1)
      begin
        dma_read_strobe_o  <= dir_read_i;
        dma_write_strobe_o <= !dir_read_i;
        repeat (2) @(posedge clk_i);
        dma_read_strobe_o  <= 1'b0;
        dma_write_strobe_o <= 1'b0;
        strobe_count_o     <= strobe_count_o + 1;
        // Gap long enough for the two-stage synchroniser to see each edge
        repeat (slow_i ? 8 : 4) @(posedge clk_i);
      end
    end
  end
endmodule // sdf_dma_host

/* File: sdf_feature_ctrl.sv */
// SCSI DMA feature control: option and feature registers, DMA handshake shaping
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
module sdf_feature_ctrl
  import sdf_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        soft_rst_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Transfer context from the core
  input  wire logic        dma_active_i,
  input  wire logic        dma_read_i,
  input  wire logic        dma_wide_i,
  input  wire logic [1:0]  bus_mode_field_i,
  input  wire logic        target_mode_i,
  input  wire logic        xfer_done_i,
  input  wire logic        atn_active_i,
  input  wire logic        ctc_zero_i,
  input  wire logic        phase_change_i,
  input  wire logic        sync_data_in_i,
  input  wire logic        sdi_interrupted_i,
  input  wire logic [7:0]  event_count_i,
  input  wire logic [4:0]  fifo_count_i,
  input  wire logic        last_odd_byte_i,
  input  wire logic        first_word_i,
  input  wire logic [7:0]  fifo_byte_lo_i,
  input  wire logic [7:0]  fifo_byte_hi_i,
  input  wire logic        fifo_byte_par_i,
  // DMA strobes from the external controller (pins)
  input  wire logic        dma_read_strobe_i,
  input  wire logic        dma_write_strobe_i,
  // DMA side
  output logic             dma_request_o,
  output logic             dma_acknowledge_o,
  output logic      [15:0] dma_data_o,
  output logic      [1:0]  upper_parity_lane_o,
  // SCSI shaping
  output logic             fast_timing_o,
  output logic      [3:0]  max_sync_offset_o,
  output logic      [1:0]  glitch_filter_select_o,
  output logic      [5:0]  glitch_window_ns_o,
  output logic             scsi_input_enable_o,
  output logic             negation_req_ack_o,
  output logic             negation_data_o,
  output logic             queue_tag_message_enable_o,
  output logic             ten_byte_cdb_enable_o,
  output logic             back_to_back_o
);

  // ==========================================================================
  // Register bank
  logic [7:0] opt;
  logic [7:0] feat;
  logic [7:0] align;
  logic       align_en;
  logic       byte_order_control;
  logic       ack_q;
  logic [7:0] next_opt;
  logic [7:0] next_feat;
  logic [7:0] next_align;
  logic       next_align_en;
  logic       next_boc;
  logic       next_ack;
  logic [7:0] rd_byte;
  logic       wr_go;
  logic       hit;
  logic [3:0] idx;
  assign idx   = wb_adr_i[5:2];
  assign hit   = (idx == SDF_IDX_OPT) || (idx == SDF_IDX_FEAT) ||
                 (idx == SDF_IDX_ALIGN) || (idx == SDF_IDX_CTL2);
  // Writes land on the acknowledging edge only
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !ack_q;
  always_comb
  begin
    next_opt      = opt;
    next_feat     = feat;
    next_align    = align;
    next_align_en = align_en;
    next_boc      = byte_order_control;
    next_ack      = wb_cyc_i && wb_stb_i && !ack_q;
    rd_byte       = 8'h00;
    if (wr_go)
    begin
      case (idx)
        SDF_IDX_OPT:  next_opt = wb_dat_i[7:0];
        SDF_IDX_FEAT: next_feat = {wb_dat_i[7:5], feat[SDF_FEAT_RES4], wb_dat_i[3:0]};
        SDF_IDX_CTL2:
        begin
          next_align_en = wb_dat_i[SDF_CTL2_DAE];
          next_boc      = wb_dat_i[SDF_CTL2_SBO];
        end
        SDF_IDX_ALIGN:
        begin
          next_align = wb_dat_i[7:0];
          if (sync_data_in_i && sdi_interrupted_i)
            next_align_en = 1'b0;
        end
        default: ;
      endcase
    end
    case (idx)
      SDF_IDX_OPT:  rd_byte = opt;
      // Bit 3 reads back reserved zero: the negation bit is write only
      SDF_IDX_FEAT: rd_byte = feat & 8'hF7;
      SDF_IDX_CTL2: rd_byte = {align_en, 1'b0, byte_order_control, 5'h00};
      default:      rd_byte = 8'h00;
    endcase
    if (rst_i || soft_rst_i)
    begin
      next_opt      = SDF_OPT_RESET;
      next_feat     = SDF_FEAT_RESET;
      next_align    = SDF_ALIGN_RESET;
      next_align_en = 1'b0;
      next_boc      = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    opt                <= next_opt;
    feat               <= next_feat;
    align              <= next_align;
    align_en           <= next_align_en;
    byte_order_control <= next_boc;
    if (rst_i)
    begin
      ack_q    <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_q    <= next_ack;
      wb_ack_o <= next_ack && hit;
      wb_err_o <= next_ack && !hit;
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // ==========================================================================
  // Static feature outputs
  logic       fast_bus_timing;
  logic       high_clock_select;
  logic       last_byte_mode;
  logic       modified_acknowledge_mode;
  logic       burst_of_eight_mode;
  logic [1:0] glitch_filter_select;
  assign fast_bus_timing           = opt[SDF_OPT_FAST];
  assign high_clock_select         = opt[SDF_OPT_HCLK];
  assign last_byte_mode            = opt[SDF_OPT_LAST_BYTE_MODE];
  assign modified_acknowledge_mode = opt[SDF_OPT_MDM];
  assign burst_of_eight_mode       = opt[SDF_OPT_BS8];
  assign glitch_filter_select      = feat[SDF_FEAT_GF_HI:SDF_FEAT_GF_LO];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fast_timing_o              <= 1'b0;
      max_sync_offset_o          <= SDF_OFS_NORMAL;
      glitch_filter_select_o     <= 2'b00;
      glitch_window_ns_o         <= 6'(SDF_GF_SE_00);
      scsi_input_enable_o        <= 1'b1;
      negation_req_ack_o         <= 1'b0;
      negation_data_o            <= 1'b0;
      queue_tag_message_enable_o <= 1'b0;
      ten_byte_cdb_enable_o      <= 1'b0;
      back_to_back_o             <= 1'b1;
    end
    else
    begin
      fast_timing_o     <= fast_bus_timing && high_clock_select;
      // Code 10 is reserved; it is given the burst offset rather than left undefined
      max_sync_offset_o <= (modified_acknowledge_mode || burst_of_eight_mode) ?
                           SDF_OFS_BURST : SDF_OFS_NORMAL;
      glitch_filter_select_o <= glitch_filter_select;
      case (glitch_filter_select)
        2'b00:   glitch_window_ns_o <= 6'(SDF_GF_SE_00);
        2'b10:   glitch_window_ns_o <= 6'(SDF_GF_SE_10);
        2'b01:   glitch_window_ns_o <= 6'(SDF_GF_SE_01);
        default: glitch_window_ns_o <= 6'(SDF_GF_SE_11);
      endcase
      scsi_input_enable_o <= !feat[SDF_FEAT_PWD];
      negation_req_ack_o  <= feat[SDF_FEAT_RAE] || feat[SDF_FEAT_NEGATION_ALL_LINES_ENABLE];
      negation_data_o     <= feat[SDF_FEAT_NEGATION_ALL_LINES_ENABLE];
      queue_tag_message_enable_o <= opt[SDF_OPT_QUEUE_TAG_MESSAGE_ENABLE];
      ten_byte_cdb_enable_o      <= opt[SDF_OPT_TEN_BYTE_CDB_ENABLE];
      back_to_back_o             <= 1'b1;
    end
  end

  // ==========================================================================
  // DMA strobe synchronisers and edge detect
  logic [1:0] rd_sync;
  logic [1:0] wr_sync;
  logic       rd_last;
  logic       wr_last;
  logic       strobe_edge;
  logic       rd_edge;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_sync <= 2'b00;
      wr_sync <= 2'b00;
      rd_last <= 1'b0;
      wr_last <= 1'b0;
    end
    else
    begin
      rd_sync <= {rd_sync[0], dma_read_strobe_i};
      wr_sync <= {wr_sync[0], dma_write_strobe_i};
      rd_last <= rd_sync[1];
      wr_last <= wr_sync[1];
    end
  end

  assign rd_edge     = rd_sync[1] && !rd_last;
  assign strobe_edge = rd_edge || (wr_sync[1] && !wr_last);

  // ==========================================================================
  // Request decision
  logic last_byte_mode_applies;
  logic hold_last;
  logic burst_ok;
  logic end_of_xfer;
  logic want_req;
  // Byte-order control in bus mode 10 and 8-bit mode bypass last-byte handling
  assign last_byte_mode_applies = dma_wide_i &&
                        !(bus_mode_field_i == SDF_BUS_MODE_FIELD_BYTE && byte_order_control);
  assign hold_last    = last_byte_mode && last_byte_mode_applies && last_odd_byte_i;
  assign end_of_xfer  = target_mode_i ? (xfer_done_i || atn_active_i)
                                      : (ctc_zero_i || phase_change_i);
  always_comb
  begin
    if (!dma_read_i)
      burst_ok = (SDF_FIFO_BYTES - fifo_count_i) >= SDF_BURST_BYTES;
    else if (end_of_xfer)
      burst_ok = fifo_count_i != 5'h00;
    else if (!target_mode_i)
      burst_ok = (fifo_count_i >= SDF_BURST_BYTES) &&
                 (!sync_data_in_i || event_count_i > SDF_EVT_MIN);
    else
      burst_ok = 1'b0;
  end
  assign want_req = dma_active_i && !hold_last && (!burst_of_eight_mode || burst_ok);

  // ==========================================================================
  // Handshake state machine
  sdf_dma_t state;
  sdf_dma_t next_state;
  logic     next_req;
  logic     next_dma_acknowledge;
  logic     hold_ack;
  // Held acknowledge, except DMA read in bus mode 11
  assign hold_ack = modified_acknowledge_mode &&
                    !(dma_read_i && bus_mode_field_i == SDF_BUS_MODE_FIELD_MUX);
  always_comb
  begin
    next_state = state;
    next_req   = 1'b0;
    next_dma_acknowledge  = 1'b0;
    case (state)
      SDF_DMA_IDLE:
        if (want_req)
          next_state = SDF_DMA_REQ;
      SDF_DMA_REQ:
      begin
        next_req  = want_req;
        next_dma_acknowledge = want_req;
        if (!want_req)
          next_state = SDF_DMA_IDLE;
        else if (strobe_edge)
          next_state = SDF_DMA_ACK;
      end
      SDF_DMA_ACK:
      begin
        // Strobe pulses the request and acknowledge low unless held
        next_req   = burst_of_eight_mode && want_req;
        next_dma_acknowledge  = hold_ack;
        next_state = SDF_DMA_REQ;
      end
      default: next_state = SDF_DMA_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_rst_i)
    begin
      state             <= SDF_DMA_IDLE;
      dma_request_o     <= 1'b0;
      dma_acknowledge_o <= 1'b0;
    end
    else
    begin
      state             <= next_state;
      dma_request_o     <= next_req;
      dma_acknowledge_o <= next_dma_acknowledge;
    end
  end

  // ==========================================================================
  // Data word shaping
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dma_data_o          <= 16'h0000;
      upper_parity_lane_o <= 2'b00;
    end
    else if (first_word_i && align_en && sync_data_in_i)
    begin
      dma_data_o          <= {fifo_byte_lo_i, align};
      upper_parity_lane_o <= {fifo_byte_par_i, ^align};
    end
    else if (last_odd_byte_i && !last_byte_mode && last_byte_mode_applies)
    begin
      dma_data_o          <= {8'hFF, fifo_byte_lo_i};
      upper_parity_lane_o <= {1'b1, fifo_byte_par_i};
    end
    else
    begin
      dma_data_o          <= {fifo_byte_hi_i, fifo_byte_lo_i};
      upper_parity_lane_o <= {^fifo_byte_hi_i, fifo_byte_par_i};
    end
  end

  // ==========================================================================
  // Checks
  fast_needs_both_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fast_timing_o |-> $past(fast_bus_timing && high_clock_select))
    else $error("fast timing without both bits");
  last_byte_mode_reset_a: assert property (@(posedge clk_i)
    $past(rst_i || soft_rst_i) |-> !last_byte_mode)
    else $error("last byte mode survived reset");
  feat_reset_a: assert property (@(posedge clk_i)
    $past(rst_i) |-> feat == SDF_FEAT_RESET)
    else $error("feature register reset value wrong");
  pwd_buffers_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(feat[SDF_FEAT_PWD]) && !$past(rst_i) |-> !scsi_input_enable_o)
    else $error("inputs enabled in power down");
  negation_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    negation_data_o |-> negation_req_ack_o)
    else $error("data negation without req ack");
  hold_last_a: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    hold_last |=> !dma_request_o)
    else $error("request raised for held last byte");
  offset_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (!$past(modified_acknowledge_mode) && !$past(burst_of_eight_mode))
        |-> max_sync_offset_o == SDF_OFS_NORMAL)
    else $error("normal mode offset wrong");
  burst_write_a: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    (burst_of_eight_mode && !dma_read_i && fifo_count_i > 5'h08) |=> !dma_request_o)
    else $error("burst write request without room");
  align_clear_a: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    (wr_go && idx == SDF_IDX_ALIGN && sync_data_in_i && sdi_interrupted_i) |=> !align_en)
    else $error("alignment enable not cleared");
  unused_store_a: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    (wr_go && idx == SDF_IDX_FEAT) |=> feat[SDF_FEAT_NU] == $past(wb_dat_i[0]))
    else $error("unused bit not stored");

  req_seen_c:   cover property (@(posedge clk_i) dma_request_o);
  ack_held_c:   cover property (@(posedge clk_i) dma_acknowledge_o ##1 dma_acknowledge_o);
  fast_c:       cover property (@(posedge clk_i) fast_timing_o);
  align_word_c: cover property (@(posedge clk_i) first_word_i && align_en && sync_data_in_i);

endmodule // sdf_feature_ctrl

/* File: sdf_pkg.sv */
// Package of register offsets, field positions, reset values and codes
package sdf_pkg;

  // ==========================================================================
  // Register offsets (printed offsets are byte-register indices)
  localparam logic [3:0] SDF_IDX_OPT   = 4'hC;
  localparam logic [3:0] SDF_IDX_FEAT  = 4'hD;
  localparam logic [3:0] SDF_IDX_ALIGN = 4'hF;
  localparam logic [3:0] SDF_IDX_CTL2  = 4'hB;

  // ==========================================================================
  // Option control fields
  localparam int SDF_OPT_QUEUE_TAG_MESSAGE_ENABLE = 6;
  localparam int SDF_OPT_TEN_BYTE_CDB_ENABLE = 5;
  localparam int SDF_OPT_FAST = 4;
  localparam int SDF_OPT_HCLK = 3;
  localparam int SDF_OPT_LAST_BYTE_MODE = 2;
  localparam int SDF_OPT_MDM  = 1;
  localparam int SDF_OPT_BS8  = 0;
  localparam logic [7:0] SDF_OPT_RESET = 8'h00;

  // ==========================================================================
  // Feature control fields
  localparam int SDF_FEAT_GF_HI = 7;
  localparam int SDF_FEAT_GF_LO = 6;
  localparam int SDF_FEAT_PWD   = 5;
  localparam int SDF_FEAT_RES4  = 4;
  localparam int SDF_FEAT_RAE   = 3;
  localparam int SDF_FEAT_NEGATION_ALL_LINES_ENABLE  = 2;
  localparam int SDF_FEAT_NU    = 0;
  localparam logic [7:0] SDF_FEAT_RESET = 8'h10;

  // ==========================================================================
  // Second control register fields held here
  localparam int SDF_CTL2_DAE = 7;
  localparam int SDF_CTL2_SBO = 5;
  localparam logic [7:0] SDF_ALIGN_RESET = 8'h00;

  // ==========================================================================
  // Codes
  localparam logic [1:0] SDF_BUS_MODE_FIELD_BYTE = 2'h2;
  localparam logic [1:0] SDF_BUS_MODE_FIELD_MUX  = 2'h3;
  localparam logic [3:0] SDF_OFS_NORMAL = 4'hF;
  localparam logic [3:0] SDF_OFS_BURST  = 4'h7;
  localparam logic [4:0] SDF_BURST_BYTES = 5'h08;
  localparam logic [4:0] SDF_FIFO_BYTES  = 5'h10;
  localparam logic [7:0] SDF_EVT_MIN     = 8'h07;
  localparam int SDF_GF_SE_00 = 12;
  localparam int SDF_GF_SE_10 = 25;
  localparam int SDF_GF_SE_01 = 35;
  localparam int SDF_GF_SE_11 = 0;
  localparam int SDF_GF_DF_00 = 0;
  localparam int SDF_GF_DF_11 = 12;
  localparam int SDF_CLK_MHZ  = 100;

  typedef enum logic [1:0]
  {
    SDF_DMA_IDLE = 2'b00,
    SDF_DMA_REQ  = 2'b01,
    SDF_DMA_ACK  = 2'b11
  } sdf_dma_t;

endpackage
